// file: hdl/irrc_pkg.sv
`default_nettype none

package irrc_pkg;

	localparam int AXI_ADDR_W = 18;
	localparam int AXI_DATA_W = 32;
	localparam int AXI_STRB_W = 4;
	localparam int DIV_W = 14;

	// register indices; byte address is four times the index
	localparam logic [15:0] CFG_IDX = 16'h5340;
	localparam logic [15:0] CAR_IDX = 16'h5342;
	localparam logic [15:0] LCNT_IDX = 16'h5344;
	localparam logic [15:0] INT_IDX = 16'h5346;

	localparam int CFG_CG_LSB = 12;
	localparam int CFG_LC_LSB = 8;
	localparam int CFG_MODE_BIT = 1;
	localparam int CFG_EN_BIT = 0;
	localparam int CAR_LOW_LSB = 8;
	localparam int CAR_HIGH_LSB = 0;
	localparam int LCNT_LEN_LSB = 8;
	localparam int LCNT_DATA_BIT = 0;
	localparam int INT_FLAG_LSB = 0;
	localparam int INT_IE_LSB = 8;
	localparam int FLAG_UF = 0;
	localparam int FLAG_RISE = 1;
	localparam int FLAG_FALL = 2;

	localparam logic [3:0] DIV_SEL_RST = 4'h0;
	localparam logic [5:0] CAR_LEN_RST = 6'h00;
	localparam logic [7:0] LEN_RST = 8'h00;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CAR_HIGH = 2'b01,
		CAR_LOW = 2'b10
	} irrc_phase_e;

	typedef struct packed {
		logic [3:0] cg_sel;
		logic [3:0] lc_sel;
		logic mode;
		logic en;
	} irrc_cfg_s;

	typedef struct packed {
		logic [5:0] low;
		logic [5:0] high;
	} irrc_car_s;

endpackage : irrc_pkg

`default_nettype wire

// file: hdl/irrc_prescaler.sv
`default_nettype none

module irrc_prescaler #(
	parameter int DIV_W = irrc_pkg::DIV_W
) (
	input wire logic clk_i, // block clock
	input wire logic rst_i, // async reset, active high
	input wire logic en_i, // run the divider
	input wire logic [3:0] sel_i, // power-of-two select code
	output logic tick_o // one-cycle divided clock pulse
);
	import irrc_pkg::*;

	if (DIV_W < 1 || DIV_W > 14)
	begin : g_bad_div_w
		$error("irrc_prescaler: DIV_W must be 1 to 14");
	end

	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic [DIV_W-1:0] mask;

	// low sel bits set: tick every 2**sel cycles
	function automatic logic [DIV_W-1:0] sel_mask(input logic [3:0] sel);
		logic [DIV_W-1:0] m;
		m = '0;
		for (int i = 0; i < DIV_W; i++)
			m[i] = (i < int'(sel));
		return m;
	endfunction

	always_comb
	begin
		mask = sel_mask(sel_i);
		cnt_d = en_i ? cnt_q + 1'b1 : '0;
		// codes beyond the divider width are reserved and never tick
		tick_o = en_i && (int'(sel_i) <= DIV_W) && ((cnt_q & mask) == mask);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule // irrc_prescaler

`default_nettype wire

// file: hdl/irrc_edge_filter.sv
`default_nettype none

module irrc_edge_filter (
	input wire logic clk_i, // block clock
	input wire logic rst_i, // async reset, active high
	input wire logic en_i, // receive detection running
	input wire logic tick_i, // sampling pulse
	input wire logic din_i, // synchronised receive level
	output logic level_o, // filtered level
	output logic rise_o, // one-cycle rising edge pulse
	output logic fall_o // one-cycle falling edge pulse
);
	logic smp_q, smp_d;
	logic level_q, level_d;
	logic rise_q, rise_d;
	logic fall_q, fall_d;

	always_comb
	begin
		smp_d = smp_q;
		level_d = level_q;
		rise_d = 1'b0;
		fall_d = 1'b0;
		if (!en_i)
		begin
			// track the pin while idle so enabling raises no false edge
			smp_d = din_i;
			level_d = din_i;
		end
		else if (tick_i)
		begin
			smp_d = din_i;
			// new level must be seen on two samples in a row
			if (din_i == smp_q && din_i != level_q)
			begin
				level_d = din_i;
				rise_d = din_i;
				fall_d = !din_i;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			smp_q <= 1'b0;
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			smp_q <= smp_d;
			level_q <= level_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	assign level_o = level_q;
	assign rise_o = rise_q;
	assign fall_o = fall_q;

endmodule // irrc_edge_filter

`default_nettype wire

// file: hdl/irrc_top.sv
// Contract
// - carrier clock is the block clock divided by 2**code, code 0xf reserved
// - carrier high for high length plus one, low for low length plus one
// - written length loads, counts down per tick, flags underflow, holds zero
// - length counter clock has its own divider with the same codes
// - direction bit 0 transmits, 1 receives; resets to transmit
// - enable bit starts modulated output or edge detection per direction
// - transmit output is carrier when data level is 1, low when 0
// - underflow requests an interrupt only when its enable is set
// - receive input sampled on carrier clock; rises and falls flagged
// - rising and falling edge requests each have their own enable
// - an edge counts only when new level holds two samples
// - in receive mode the data level bit shows the received level
// - underflow is also flagged in receive mode
// - three flags, each gated by its enable, form one request line
// - flags stay set until written with 1; writing 0 keeps them
`default_nettype none

module irrc_top (
	input wire logic REF_CLK_I, // block clock, 20 MHz
	input wire logic RST_I, // async reset, active high
	input wire logic [irrc_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I, // write addr
	input wire logic S_AXI_AWVALID_I, // write address valid
	output logic S_AXI_AWREADY_O, // write address ready
	input wire logic [irrc_pkg::AXI_DATA_W-1:0] S_AXI_WDATA_I, // write data
	input wire logic [irrc_pkg::AXI_STRB_W-1:0] S_AXI_WSTRB_I, // byte lanes
	input wire logic S_AXI_WVALID_I, // write data valid
	output logic S_AXI_WREADY_O, // write data ready
	output logic [1:0] S_AXI_BRESP_O, // write response
	output logic S_AXI_BVALID_O, // write response valid
	input wire logic S_AXI_BREADY_I, // write response ready
	input wire logic [irrc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR_I, // read addr
	input wire logic S_AXI_ARVALID_I, // read address valid
	output logic S_AXI_ARREADY_O, // read address ready
	output logic [irrc_pkg::AXI_DATA_W-1:0] S_AXI_RDATA_O, // read data
	output logic [1:0] S_AXI_RRESP_O, // read response
	output logic S_AXI_RVALID_O, // read data valid
	input wire logic S_AXI_RREADY_I, // read data ready
	input wire logic IR_RECEIVE_INPUT_I, // receiver pin, asynchronous
	output logic IR_TRANSMIT_OUTPUT_O, // modulated emitter drive
	output logic IRQ_O // request to interrupt controller, high
);
	import irrc_pkg::*;

	if (AXI_ADDR_W < 18)
	begin : g_bad_addr_w
		$error("irrc_top: address too narrow for register map");
	end

	// bus slave state
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [AXI_ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [15:0] w_data_q, w_data_d;
	logic [1:0] w_strb_q, w_strb_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [AXI_DATA_W-1:0] rdata_q, rdata_d;
	logic aw_take, w_take, ar_take, do_write;
	logic [3:0] wsel, rsel;

	// block state
	irrc_cfg_s cfg_q, cfg_d;
	irrc_car_s car_q, car_d;
	logic data_bit_q, data_bit_d;
	logic [7:0] len_q, len_d;
	logic [2:0] ie_q, ie_d, flags_q, flags_d, flag_set, flag_clr;
	irrc_phase_e phase_q, phase_d;
	logic [5:0] ph_cnt_q, ph_cnt_d;
	logic tx_q, tx_d, irq_q, irq_d;
	logic rx_meta_q, rx_sync_q;
	logic cg_tick, lc_tick, rx_level, rx_rise, rx_fall;
	logic wr_len, uf_evt, rx_en;
	logic [15:0] cfg_w;

	// one-hot register select; bits: cfg, car, lcnt, int
	function automatic logic [3:0] reg_sel(input logic [AXI_ADDR_W-1:0] a);
		logic [15:0] idx;
		idx = a[17:2];
		return {idx == INT_IDX, idx == LCNT_IDX, idx == CAR_IDX,
			idx == CFG_IDX};
	endfunction

	// byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic [15:0] rd_word(input logic [3:0] sel,
		input irrc_cfg_s c, input irrc_car_s k, input logic [7:0] len,
		input logic dbit, input logic [2:0] ie, input logic [2:0] fl);
		logic [15:0] v;
		v = 16'h0000;
		case (1'b1)
			sel[0]:
			begin
				v[CFG_CG_LSB +: 4] = c.cg_sel;
				v[CFG_LC_LSB +: 4] = c.lc_sel;
				v[CFG_MODE_BIT] = c.mode;
				v[CFG_EN_BIT] = c.en;
			end
			sel[1]:
			begin
				v[CAR_LOW_LSB +: 6] = k.low;
				v[CAR_HIGH_LSB +: 6] = k.high;
			end
			sel[2]:
			begin
				v[LCNT_LEN_LSB +: 8] = len;
				v[LCNT_DATA_BIT] = dbit;
			end
			sel[3]:
			begin
				v[INT_IE_LSB +: 3] = ie;
				v[INT_FLAG_LSB +: 3] = fl;
			end
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// AXI4-Lite slave: address and data taken in either order
	always_comb
	begin
		aw_take = S_AXI_AWVALID_I && awready_q;
		w_take = S_AXI_WVALID_I && wready_q;
		ar_take = S_AXI_ARVALID_I && arready_q;
		do_write = aw_held_q && w_held_q && !bvalid_q;
		wsel = reg_sel(aw_addr_q);
		rsel = reg_sel(S_AXI_ARADDR_I);
		aw_addr_d = aw_take ? S_AXI_AWADDR_I : aw_addr_q;
		w_data_d = w_take ? S_AXI_WDATA_I[15:0] : w_data_q;
		w_strb_d = w_take ? S_AXI_WSTRB_I[1:0] : w_strb_q;
		aw_held_d = (aw_held_q || aw_take) && !do_write;
		w_held_d = (w_held_q || w_take) && !do_write;
		awready_d = !aw_held_d;
		wready_d = !w_held_d;
		bvalid_d = do_write || (bvalid_q && !S_AXI_BREADY_I);
		bresp_d = bresp_q;
		if (do_write)
			bresp_d = (wsel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
		rvalid_d = ar_take || (rvalid_q && !S_AXI_RREADY_I);
		arready_d = !rvalid_d;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (ar_take)
		begin
			// receive mode shows the filtered receive level in the data bit
			rdata_d = {16'h0000, rd_word(rsel, cfg_q, car_q, len_q,
				cfg_q.mode ? rx_level : data_bit_q, ie_q, flags_q)};
			rresp_d = (rsel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
		end
	end

	irrc_prescaler #(
		.DIV_W(DIV_W)
	) u_cg_div (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.en_i(cfg_q.en),
		.sel_i(cfg_q.cg_sel),
		.tick_o(cg_tick)
	);

	irrc_prescaler #(
		.DIV_W(DIV_W)
	) u_lc_div (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.en_i(cfg_q.en),
		.sel_i(cfg_q.lc_sel),
		.tick_o(lc_tick)
	);

	assign rx_en = cfg_q.en && cfg_q.mode;

	irrc_edge_filter u_edge (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.en_i(rx_en),
		.tick_i(cg_tick),
		.din_i(rx_sync_q),
		.level_o(rx_level),
		.rise_o(rx_rise),
		.fall_o(rx_fall)
	);

	// registers, length counter, flags, carrier and outputs
	always_comb
	begin
		cfg_d = cfg_q;
		car_d = car_q;
		data_bit_d = data_bit_q;
		ie_d = ie_q;
		flag_clr = 3'h0;
		wr_len = 1'b0;
		cfg_w = merge(rd_word(4'h1, cfg_q, car_q, len_q, data_bit_q,
			ie_q, flags_q), w_data_q, w_strb_q);
		if (do_write)
		begin
			// word layout differs from the packed struct, so unpack by field
			if (wsel[0])
				cfg_d = '{cfg_w[CFG_CG_LSB +: 4], cfg_w[CFG_LC_LSB +: 4],
					cfg_w[CFG_MODE_BIT], cfg_w[CFG_EN_BIT]};
			if (wsel[1])
				car_d = {w_data_q[CAR_LOW_LSB +: 6] & {6{w_strb_q[1]}} |
					car_q.low & {6{!w_strb_q[1]}},
					w_data_q[CAR_HIGH_LSB +: 6] & {6{w_strb_q[0]}} |
					car_q.high & {6{!w_strb_q[0]}}};
			if (wsel[2] && w_strb_q[0])
				data_bit_d = w_data_q[LCNT_DATA_BIT];
			if (wsel[2])
				wr_len = w_strb_q[1];
			if (wsel[3] && w_strb_q[1])
				ie_d = w_data_q[INT_IE_LSB +: 3];
			if (wsel[3] && w_strb_q[0])
				flag_clr = w_data_q[INT_FLAG_LSB +: 3];
		end
		len_d = len_q;
		uf_evt = 1'b0;
		if (wr_len)
			len_d = w_data_q[LCNT_LEN_LSB +: 8];
		else if (cfg_q.en && lc_tick && len_q != 8'h00)
		begin
			len_d = len_q - 8'h01;
			uf_evt = (len_q == 8'h01);
		end
		flag_set = 3'h0;
		flag_set[FLAG_UF] = uf_evt;
		flag_set[FLAG_RISE] = rx_rise;
		flag_set[FLAG_FALL] = rx_fall;
		// a new event in the clearing cycle survives the clear
		flags_d = (flags_q & ~flag_clr) | flag_set;
		irq_d = |(flags_d & ie_d);
		phase_d = phase_q;
		ph_cnt_d = ph_cnt_q;
		if (!cfg_q.en)
		begin
			phase_d = CAR_HIGH;
			ph_cnt_d = 6'h00;
		end
		else if (cg_tick)
		begin
			case (phase_q)
				CAR_HIGH:
					if (ph_cnt_q == car_q.high)
					begin
						phase_d = CAR_LOW;
						ph_cnt_d = 6'h00;
					end
					else
						ph_cnt_d = ph_cnt_q + 6'h01;
				CAR_LOW:
					if (ph_cnt_q == car_q.low)
					begin
						phase_d = CAR_HIGH;
						ph_cnt_d = 6'h00;
					end
					else
						ph_cnt_d = ph_cnt_q + 6'h01;
				default:
				begin
					phase_d = CAR_HIGH;
					ph_cnt_d = 6'h00;
				end
			endcase
		end
		tx_d = cfg_q.en && !cfg_q.mode && data_bit_q &&
			(phase_q == CAR_HIGH);
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 16'h0000;
			w_strb_q <= 2'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			cfg_q <= {DIV_SEL_RST, DIV_SEL_RST, 1'b0, 1'b0};
			car_q <= {CAR_LEN_RST, CAR_LEN_RST};
			data_bit_q <= 1'b0;
			len_q <= LEN_RST;
			ie_q <= FLAGS_RST;
			flags_q <= FLAGS_RST;
			phase_q <= CAR_HIGH;
			ph_cnt_q <= 6'h00;
			tx_q <= 1'b0;
			irq_q <= 1'b0;
			rx_meta_q <= 1'b0;
			rx_sync_q <= 1'b0;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			cfg_q <= cfg_d;
			car_q <= car_d;
			data_bit_q <= data_bit_d;
			len_q <= len_d;
			ie_q <= ie_d;
			flags_q <= flags_d;
			phase_q <= phase_d;
			ph_cnt_q <= ph_cnt_d;
			tx_q <= tx_d;
			irq_q <= irq_d;
			rx_meta_q <= IR_RECEIVE_INPUT_I;
			rx_sync_q <= rx_meta_q;
		end
	end

	assign S_AXI_AWREADY_O = awready_q;
	assign S_AXI_WREADY_O = wready_q;
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O = bresp_q;
	assign S_AXI_ARREADY_O = arready_q;
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RRESP_O = rresp_q;
	assign S_AXI_RDATA_O = rdata_q;
	assign IR_TRANSMIT_OUTPUT_O = tx_q;
	assign IRQ_O = irq_q;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	sequence high_end_s;
		phase_q == CAR_HIGH && cg_tick && ph_cnt_q == car_q.high;
	endsequence

	carrier_high_a: assert property (high_end_s |=> phase_q == CAR_LOW)
		else $error("carrier high phase did not end on its length");
	carrier_hold_a: assert property ((cfg_q.en && !cg_tick) |=>
		$stable(phase_q) && $stable(ph_cnt_q))
		else $error("carrier moved without a carrier tick");
	tx_disabled_a: assert property (!cfg_q.en |=> !IR_TRANSMIT_OUTPUT_O)
		else $error("transmit output high while disabled");
	tx_level_a: assert property ((cfg_q.en && !cfg_q.mode && !data_bit_q)
		|=> !IR_TRANSMIT_OUTPUT_O)
		else $error("transmit output high with data level 0");
	cnt_load_a: assert property (wr_len |=>
		len_q == $past(w_data_q[LCNT_LEN_LSB +: 8]))
		else $error("length counter did not load written value");
	cnt_dec_a: assert property ((cfg_q.en && lc_tick && !wr_len &&
		len_q != 8'h00) |=> len_q == $past(len_q) - 8'h01)
		else $error("length counter did not decrement");
	cnt_stop_a: assert property ((len_q == 8'h00 && !wr_len) |=>
		len_q == 8'h00 && !uf_evt)
		else $error("length counter left zero without a write");
	flag_keep_a: assert property ((flags_q[FLAG_UF] && !flag_clr[FLAG_UF])
		|=> flags_q[FLAG_UF])
		else $error("underflow flag dropped without a clear");
	irq_gate_a: assert property (!(|(flags_q & ie_q)) ##1
		!(|(flags_q & ie_q)) |-> !IRQ_O)
		else $error("request raised with no enabled flag");
	no_cause_a: assert property (!cfg_q.en |-> !uf_evt ##1
		(!rx_rise && !rx_fall))
		else $error("cause raised while disabled");

endmodule // irrc_top

`default_nettype wire

// file: sim/irrc_ir_partner.sv
`default_nettype none

module irrc_ir_partner (
	input wire logic clk_i, // block clock
	input wire logic tx_i, // emitter drive from the block
	input wire logic lvl_i, // light level seen by the receiver
	output logic rx_o, // receiver module output
	output int hi_o, // last completed high run, in cycles
	output int lo_o // last completed low run, in cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	int run = 0;
	logic last = 1'b0;

	// push-pull receiver module, so the pin never floats
	assign rx_o = lvl_i;

	// the emitter only times runs; the last full run is kept, the open
	// one is not reported until the level changes
	always @(posedge clk_i)
	begin
		if (tx_i !== last)
		begin
			if (last === 1'b1)
				hi_o <= run;
			else
				lo_o <= run;
			run <= 1;
		end
		else
			run <= run + 1;
		last <= tx_i;
	end
endmodule // irrc_ir_partner

`default_nettype wire

// file: sim/irrc_top_test.sv
`default_nettype none

module irrc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import irrc_pkg::*;
	typedef struct {logic [1:0] r; logic [15:0] d; logic [15:0] m;} irrc_exp_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [AXI_ADDR_W-1:0] awaddr = '0;
	logic [AXI_ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, rx_lvl = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, tx, irq, rx;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] got;
	int hi, lo;
	int err_total = 0;
	int compares = 0;
	irrc_exp_s exp_r[$];
	logic [1:0] exp_b[$];

	always #25 clk = ~clk;

	irrc_top irrc_top_inst (
		.REF_CLK_I(clk), .RST_I(rst),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .IR_RECEIVE_INPUT_I(rx),
		.IR_TRANSMIT_OUTPUT_O(tx), .IRQ_O(irq)
	);

	irrc_ir_partner irrc_ir_partner_inst (
		.clk_i(clk), .tx_i(tx), .lvl_i(rx_lvl), .rx_o(rx),
		.hi_o(hi), .lo_o(lo)
	);

	task automatic close_out();
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	function automatic logic [AXI_ADDR_W-1:0] ad(input logic [15:0] i);
		return {i, 2'b00};
	endfunction

	// handshakes are judged at the falling edge, where the values that the
	// next rising edge will sample are already settled
	task automatic wr(input logic [15:0] i, input logic [15:0] d,
		input logic [1:0] r);
		logic at, wt;
		@(posedge clk);
		exp_b.push_back(r);
		awaddr <= ad(i);
		wdata <= {16'h0000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge clk);
			at = awvalid && awready;
			wt = wvalid && wready;
			@(posedge clk);
			if (at)
				awvalid <= 1'b0;
			if (wt)
				wvalid <= 1'b0;
		end
		while ((awvalid && !at) || (wvalid && !wt));
		do
		begin
			@(negedge clk);
			at = bvalid;
			@(posedge clk);
		end
		while (at !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] i, input logic [15:0] d,
		input logic [15:0] m, input logic [1:0] r);
		logic t;
		@(posedge clk);
		exp_r.push_back(irrc_exp_s'{r, d, m});
		araddr <= ad(i);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end
		while (t !== 1'b1);
		arvalid <= 1'b0;
		do
		begin
			@(negedge clk);
			t = rvalid;
			got = rdata[15:0];
			@(posedge clk);
		end
		while (t !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic quiet();
		int k;
		k = 0;
		repeat (4) @(posedge clk);
		repeat (40)
		begin
			@(negedge clk);
			if (tx !== 1'b0)
				k++;
		end
		chk(k, 32'h0);
	endtask

	always @(negedge clk)
	begin : mon
		irrc_exp_s e;
		if (rvalid === 1'b1 && rready)
		begin
			e = exp_r.pop_front();
			chk(rdata & {16'hffff, e.m}, {16'h0000, e.d & e.m});
			chk({30'h0, rresp}, {30'h0, e.r});
		end
		if (bvalid === 1'b1 && bready)
			chk({30'h0, bresp}, {30'h0, exp_b.pop_front()});
	end

	// the sequence needs about 1000 cycles; twenty times that means a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end

	initial
	begin
		int h, l, n;
		void'($urandom(32'h8c59));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(CFG_IDX, 16'h0000, 16'hffff, RESP_OKAY);
		rd(CAR_IDX, 16'h0000, 16'hffff, RESP_OKAY);
		rd(LCNT_IDX, 16'h0000, 16'hffff, RESP_OKAY);
		rd(INT_IDX, 16'h0000, 16'hffff, RESP_OKAY);
		rd(16'h5348, 16'h0000, 16'hffff, RESP_SLVERR);
		wr(16'h5348, 16'hffff, RESP_SLVERR);
		for (int s = 0; s < 3; s++)
		begin
			h = $urandom % 8;
			l = $urandom % 8;
			wr(CFG_IDX, 16'(s << 12), RESP_OKAY);
			wr(CAR_IDX, 16'((l << 8) | h), RESP_OKAY);
			wr(LCNT_IDX, 16'h0000, RESP_OKAY);
			wr(CFG_IDX, 16'((s << 12) | 1), RESP_OKAY);
			wr(LCNT_IDX, 16'h0001, RESP_OKAY);
			repeat ((h + l + 2) * (4 << s) + 20) @(posedge clk);
			@(negedge clk);
			chk(hi, (h + 1) << s);
			chk(lo, (l + 1) << s);
			wr(LCNT_IDX, 16'h0000, RESP_OKAY);
			quiet();
			wr(CFG_IDX, 16'h0000, RESP_OKAY);
		end
		wr(INT_IDX, 16'h0107, RESP_OKAY);
		wr(CFG_IDX, 16'h0201, RESP_OKAY);
		// six ticks of four cycles: a 1.2 us pulse at a 5 MHz count clock
		wr(LCNT_IDX, 16'h0600, RESP_OKAY);
		n = 0;
		while (irq !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		chk(n >= 20 && n <= 28, 32'h1);
		rd(LCNT_IDX, 16'h0000, 16'hff00, RESP_OKAY);
		wr(INT_IDX, 16'h0100, RESP_OKAY);
		rd(INT_IDX, 16'h0101, 16'h0707, RESP_OKAY);
		@(negedge clk);
		chk(irq, 32'h1);
		wr(CFG_IDX, 16'h0200, RESP_OKAY);
		wr(INT_IDX, 16'h0000, RESP_OKAY);
		@(negedge clk);
		chk(irq, 32'h0);
		wr(INT_IDX, 16'h0001, RESP_OKAY);
		rd(INT_IDX, 16'h0000, 16'h0707, RESP_OKAY);
		wr(CFG_IDX, 16'h0201, RESP_OKAY);
		wr(LCNT_IDX, 16'hff00, RESP_OKAY);
		repeat (8) @(posedge clk);
		wr(LCNT_IDX, 16'h1000, RESP_OKAY);
		rd(LCNT_IDX, 16'h0000, 16'h0000, RESP_OKAY);
		chk(got[15:8] <= 8'h10 && got[15:8] >= 8'h0c, 32'h1);
		wr(CFG_IDX, 16'h0200, RESP_OKAY);
		wr(LCNT_IDX, 16'h0501, RESP_OKAY);
		quiet();
		rd(LCNT_IDX, 16'h0500, 16'hff00, RESP_OKAY);
		rd(INT_IDX, 16'h0000, 16'h0007, RESP_OKAY);
		wr(LCNT_IDX, 16'h0000, RESP_OKAY);
		wr(INT_IDX, 16'h0207, RESP_OKAY);
		wr(CFG_IDX, 16'h1002, RESP_OKAY);
		wr(CFG_IDX, 16'h1003, RESP_OKAY);
		// one-cycle glitch: seen by at most one sample at this rate
		@(posedge clk);
		rx_lvl <= 1'b1;
		@(posedge clk);
		rx_lvl <= 1'b0;
		repeat (20) @(posedge clk);
		rd(INT_IDX, 16'h0200, 16'h0707, RESP_OKAY);
		rx_lvl <= 1'b1;
		repeat (20) @(posedge clk);
		rd(INT_IDX, 16'h0202, 16'h0707, RESP_OKAY);
		@(negedge clk);
		chk(irq, 32'h1);
		rd(LCNT_IDX, 16'h0001, 16'h0001, RESP_OKAY);
		wr(LCNT_IDX, 16'hff00, RESP_OKAY);
		wr(INT_IDX, 16'h0202, RESP_OKAY);
		rx_lvl <= 1'b0;
		repeat (20) @(posedge clk);
		rd(INT_IDX, 16'h0204, 16'h0707, RESP_OKAY);
		@(negedge clk);
		chk(irq, 32'h0);
		rd(LCNT_IDX, 16'h0000, 16'h0001, RESP_OKAY);
		// one count per cycle: the low pulse lasts a little over 20 cycles
		n = 255 - int'(got[15:8]);
		chk(n >= 20 && n <= 40, 32'h1);
		wr(LCNT_IDX, 16'h0300, RESP_OKAY);
		repeat (10) @(posedge clk);
		rd(INT_IDX, 16'h0001, 16'h0001, RESP_OKAY);
		wr(CFG_IDX, 16'h1002, RESP_OKAY);
		close_out();
	end
endmodule // irrc_top_test

`default_nettype wire
